// ===== hw/fcp_consts.vh
/*
 * Constants for the power-switch control and discharge protection
 * configuration block: register offsets, field positions, reset values,
 * thresholds and protection delays.
 * Assumes a 125 MHz core clock. The header is included by its bare name.
 */
// Function
// - Register contents survive sleep, except the charge and discharge bits that forced sleep clears.
// - Writing one to control bit 7 forces sleep: switches, balance, regulator off.
// - Forced sleep clears charge, discharge and balance bits, not analog select.
// - Sleep bit returns to zero automatically on wake-up.
// - Control bit 6 turns the load-voltage monitor on or off.
// - Control bit 1 drives the charge switch.
// - Charge overcurrent clears the charge bit unless auto response disabled.
// - Control bit 0 drives the discharge switch.
// - Discharge overcurrent or short clears discharge bit unless disabled.
// - Config bit 7 disables automatic switch-off on discharge overcurrent.
// - Discharge overcurrent always sets its flag and temp sensor supply.
// - Config bits 6:5 select overcurrent threshold 0.10 to 0.16 V.
// - Config bit 4 disables automatic switch-off on short circuit.
// - Short circuit always sets its flag and temp sensor supply.
// - Config bits 3:2 select short threshold 0.20 to 1.20 V.
// - Config bits 1:0 select overcurrent timeout 160 to 1280 ms, or 2.5 to 20 ms.
// - The discharge time divider divides the overcurrent delay by 64.
// - Short delay select: 190 us when zero, 10 ms when one.
// - Charge overcurrent auto-off disable bit gates the charge response.
`ifndef FCP_CONSTS_VH
`define FCP_CONSTS_VH

// Register offsets
`define FCP_ADDR_SWITCH_CTL 8'h04
`define FCP_ADDR_DISCH_CFG 8'h05
`define FCP_ADDR_TIME_SCALE 8'h06

// Switch control fields
`define FCP_CTL_SLEEP 7
`define FCP_CTL_LOAD_MON 6
`define FCP_CTL_CHARGE 1
`define FCP_CTL_DISCH 0
`define FCP_CTL_RESET 8'h00

// Discharge configuration fields
`define FCP_CFG_OC_OFF_DIS 7
`define FCP_CFG_OC_THR_HI 6
`define FCP_CFG_OC_THR_LO 5
`define FCP_CFG_SC_OFF_DIS 4
`define FCP_CFG_SC_THR_HI 3
`define FCP_CFG_SC_THR_LO 2
`define FCP_CFG_OC_TO_HI 1
`define FCP_CFG_OC_TO_LO 0
`define FCP_CFG_RESET 8'h00

// Comparator thresholds in mV, code 0 to 3
`define FCP_OC_MV_0 100
`define FCP_OC_MV_1 120
`define FCP_OC_MV_2 140
`define FCP_OC_MV_3 160
`define FCP_SC_MV_0 200
`define FCP_SC_MV_1 350
`define FCP_SC_MV_2 650
`define FCP_SC_MV_3 1200

// Timing
`define FCP_CLK_MHZ 125
`define FCP_OC_TICK_US 2500
`define FCP_OC_TICK_CYC (`FCP_OC_TICK_US * `FCP_CLK_MHZ)
`define FCP_DT_DIV 64
`define FCP_SC_SHORT_US 190
`define FCP_SC_SHORT_CYC (`FCP_SC_SHORT_US * `FCP_CLK_MHZ)
`define FCP_SC_LONG_US 10000
`define FCP_SC_LONG_CYC (`FCP_SC_LONG_US * `FCP_CLK_MHZ)

`endif

// ===== hw/fcp_persist.v
/*
 * Persistence timer: fires a one-cycle pulse once a condition has held
 * for limit counted steps, and restarts whenever the condition drops.
 * Assumes cond and step are synchronous to mclk.
 */
`timescale 1ns/100ps
module fcp_persist #(
  parameter CW = 22
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  input wire ce,
  // Condition
  input wire cond,
  input wire step,
  input wire [CW-1:0] limit,
  // Result
  output reg hit_q
);

  reg [CW-1:0] cnt_q;
  reg fired_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      fired_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (ce) begin
      hit_q <= 1'b0;
      if (!cond) begin
        // Any gap in the condition restarts the delay
        cnt_q <= {CW{1'b0}};
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        if (cnt_q >= limit) begin
          hit_q <= 1'b1;
          fired_q <= 1'b1;
        end else if (step) begin
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== hw/fcp_switch_cfg.v
/*
 * Power-switch control and discharge protection configuration registers,
 * with the discharge overcurrent and short-circuit protection response.
 * Assumes a register port from the serial interface on the same clock,
 * analog comparator and wake signals arriving asynchronously from pins,
 * and time-scale settings supplied by the neighbouring register.
 */
`timescale 1ns/100ps
`include "fcp_consts.vh"
module fcp_switch_cfg #(
  parameter OC_TICK_CYC = `FCP_OC_TICK_CYC,
  parameter SC_SHORT_CYC = `FCP_SC_SHORT_CYC,
  parameter SC_LONG_CYC = `FCP_SC_LONG_CYC
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // Settings held in the time-scale register
  input wire discharge_time_divider,
  input wire short_long_delay_sel,
  input wire charge_oc_auto_off_disable,
  // Events and pins
  input wire charge_oc_event,
  input wire discharge_oc_cmp,
  input wire short_cmp,
  input wire wake_pin,
  input wire flag_clear,
  // Switch and supply outputs
  output reg charge_switch_on_q,
  output reg discharge_switch_on_q,
  output reg load_monitor_enable_q,
  output reg regulator_enable_q,
  output reg sleep_active_q,
  output reg balance_clear_q,
  // Comparator settings
  output reg [1:0] oc_threshold_sel_q,
  output reg [1:0] short_threshold_sel_q,
  // Fault flags
  output reg discharge_oc_flag_q,
  output reg short_circuit_flag_q,
  output reg temp_sensor_supply_out_q
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Overcurrent timeout in 2.5 ms ticks
  function [9:0] fcp_oc_ticks;
    input [1:0] code;
    input div;
    reg [9:0] base;
    begin
      base = div ? 10'h001 : 10'h040;
      fcp_oc_ticks = base << code;
    end
  endfunction

  function fcp_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      fcp_hit = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] oc_sync_q;
  reg [1:0] sc_sync_q;
  reg [1:0] wake_sync_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      oc_sync_q <= 2'h0;
      sc_sync_q <= 2'h0;
      wake_sync_q <= 2'h0;
    end else if (ce) begin
      oc_sync_q <= {oc_sync_q[0], discharge_oc_cmp};
      sc_sync_q <= {sc_sync_q[0], short_cmp};
      wake_sync_q <= {wake_sync_q[0], wake_pin};
    end
  end

  wire oc_cond = oc_sync_q[1];
  wire sc_cond = sc_sync_q[1];
  wire wake = wake_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Hard reset clears these; a sleep request or protection also clears charge_q and disch_q, and wake clears sleep_q
  reg sleep_q;
  reg load_mon_q;
  reg charge_q;
  reg disch_q;
  reg [7:0] cfg_q;

  wire wr_ctl = reg_wr && fcp_hit(reg_addr, `FCP_ADDR_SWITCH_CTL);
  wire wr_cfg = reg_wr && fcp_hit(reg_addr, `FCP_ADDR_DISCH_CFG);
  wire sleep_req = wr_ctl && reg_wdata[`FCP_CTL_SLEEP];

  wire doc_hit;
  wire scd_hit;

  wire charge_kill = charge_oc_event && !charge_oc_auto_off_disable;
  wire disch_kill = (doc_hit && !cfg_q[`FCP_CFG_OC_OFF_DIS]) ||
                    (scd_hit && !cfg_q[`FCP_CFG_SC_OFF_DIS]);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
      load_mon_q <= 1'b0;
      charge_q <= 1'b0;
      disch_q <= 1'b0;
      cfg_q <= `FCP_CFG_RESET;
    end else if (ce) begin
      if (wr_ctl) begin
        load_mon_q <= reg_wdata[`FCP_CTL_LOAD_MON];
        charge_q <= reg_wdata[`FCP_CTL_CHARGE];
        disch_q <= reg_wdata[`FCP_CTL_DISCH];
      end
      if (wr_cfg) begin
        cfg_q <= reg_wdata;
      end
      // Sleep request outranks a wake seen in the same cycle
      if (sleep_req) begin
        sleep_q <= 1'b1;
      end else if (wake) begin
        sleep_q <= 1'b0;
      end
      // Protection and sleep clears override a concurrent write
      if (sleep_req || charge_kill) begin
        charge_q <= 1'b0;
      end
      if (sleep_req || disch_kill) begin
        disch_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection timers

  reg [18:0] tick_cnt_q;
  reg tick_q;

  // Prescaler restarts with the condition so the first tick is a full one
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 19'h00000;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (!oc_cond) begin
        tick_cnt_q <= 19'h00000;
      end else if (tick_cnt_q >= OC_TICK_CYC[18:0] - 19'h00001) begin
        tick_cnt_q <= 19'h00000;
        tick_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 19'h00001;
      end
    end
  end

  wire [9:0] oc_limit = fcp_oc_ticks(cfg_q[`FCP_CFG_OC_TO_HI:`FCP_CFG_OC_TO_LO],
                                     discharge_time_divider);
  wire [20:0] sc_limit = short_long_delay_sel ? SC_LONG_CYC[20:0] :
                                                SC_SHORT_CYC[20:0];

  fcp_persist #(.CW(10)) u_oc_timer (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .cond(oc_cond),
    .step(tick_q),
    .limit(oc_limit),
    .hit_q(doc_hit)
  );

  fcp_persist #(.CW(21)) u_sc_timer (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .cond(sc_cond),
    .step(1'b1),
    .limit(sc_limit),
    .hit_q(scd_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      charge_switch_on_q <= 1'b0;
      discharge_switch_on_q <= 1'b0;
      load_monitor_enable_q <= 1'b0;
      regulator_enable_q <= 1'b1;
      sleep_active_q <= 1'b0;
      balance_clear_q <= 1'b0;
      oc_threshold_sel_q <= 2'h0;
      short_threshold_sel_q <= 2'h0;
      discharge_oc_flag_q <= 1'b0;
      short_circuit_flag_q <= 1'b0;
      temp_sensor_supply_out_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      charge_switch_on_q <= charge_q && !sleep_q;
      discharge_switch_on_q <= disch_q && !sleep_q;
      load_monitor_enable_q <= load_mon_q;
      regulator_enable_q <= !sleep_q;
      sleep_active_q <= sleep_q;
      // Balance bits live next door; analog select is left alone
      balance_clear_q <= sleep_req;
      oc_threshold_sel_q <= cfg_q[`FCP_CFG_OC_THR_HI:`FCP_CFG_OC_THR_LO];
      short_threshold_sel_q <= cfg_q[`FCP_CFG_SC_THR_HI:`FCP_CFG_SC_THR_LO];
      // Flags are sticky; a new event wins over a clear
      discharge_oc_flag_q <= doc_hit || (discharge_oc_flag_q && !flag_clear);
      short_circuit_flag_q <= scd_hit || (short_circuit_flag_q && !flag_clear);
      temp_sensor_supply_out_q <= doc_hit || scd_hit ||
                                  ((discharge_oc_flag_q || short_circuit_flag_q) &&
                                   !flag_clear);
      // Reserved control bits read as zero
      if (fcp_hit(reg_addr, `FCP_ADDR_SWITCH_CTL)) begin
        reg_rdata_q <= {sleep_q, load_mon_q, 4'h0, charge_q, disch_q};
      end else if (fcp_hit(reg_addr, `FCP_ADDR_DISCH_CFG)) begin
        reg_rdata_q <= cfg_q;
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

endmodule

// ===== verification/fcp_switch_cfg_props.sv
/* Checker for the switch control and discharge protection block.
   Assumes it is bound onto fcp_switch_cfg and sees only its ports. */
`timescale 1ns/100ps
module fcp_switch_cfg_props (
  // Clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // Register port and events
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire charge_oc_event,
  input wire short_cmp,
  input wire wake_pin,
  // Switch and supply outputs
  input wire charge_switch_on_q,
  input wire discharge_switch_on_q,
  input wire load_monitor_enable_q,
  input wire regulator_enable_q,
  input wire sleep_active_q,
  input wire balance_clear_q,
  // Comparator settings
  input wire [1:0] oc_threshold_sel_q,
  input wire [1:0] short_threshold_sel_q,
  // Fault flags
  input wire discharge_oc_flag_q,
  input wire short_circuit_flag_q,
  input wire temp_sensor_supply_out_q
);
  // Shadow of the auto-off disable bits, needed to judge the switch response
  reg [7:0] cfg_q;
  wire w4 = ce && reg_wr && reg_addr == 8'h04;
  wire w5 = ce && reg_wr && reg_addr == 8'h05;
  always @(posedge mclk or posedge rst)
    if (rst) cfg_q <= 8'h00;
    else if (w5) cfg_q <= reg_wdata;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////
  property p_sleep_off;
    sleep_active_q |-> !charge_switch_on_q && !discharge_switch_on_q && !regulator_enable_q;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("output on while asleep");
  property p_bal;
    w4 && reg_wdata[7] |-> ##[1:2] balance_clear_q;
  endproperty
  a_bal: assert property (p_bal) else $error("no balance clear pulse");
  property p_temp;
    discharge_oc_flag_q || short_circuit_flag_q |-> temp_sensor_supply_out_q;
  endproperty
  a_temp: assert property (p_temp) else $error("sensor supply off");
  property p_thr;
    w5 |-> ##2 oc_threshold_sel_q == $past(reg_wdata[6:5], 2)
      && short_threshold_sel_q == $past(reg_wdata[3:2], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold select wrong");
  property p_chg;
    w4 && !reg_wdata[7] && !sleep_active_q && !charge_oc_event |-> ##2
      charge_switch_on_q == $past(reg_wdata[1], 2) && load_monitor_enable_q == $past(reg_wdata[6], 2);
  endproperty
  a_chg: assert property (p_chg) else $error("control bits not applied");
  property p_dclr;
    ($rose(short_circuit_flag_q) && !cfg_q[4]) || ($rose(discharge_oc_flag_q) && !cfg_q[7])
      |-> ##1 !discharge_switch_on_q;
  endproperty
  a_dclr: assert property (p_dclr) else $error("discharge left on");
  property p_short;
    $rose(short_circuit_flag_q) |-> $past(short_cmp, 3) && $past(short_cmp, 7);
  endproperty
  a_short: assert property (p_short) else $error("short flag too early");
  property p_wake;
    wake_pin [*6] |-> !sleep_active_q;
  endproperty
  a_wake: assert property (p_wake) else $error("still asleep after wake");
endmodule
bind fcp_switch_cfg fcp_switch_cfg_props fcp_switch_cfg_props_inst (.*);

// ===== verification/fcp_mcu_model.sv
/* Microcontroller model that writes and selects registers.
   Assumes one clock shared with the block. */
`timescale 1ns/100ps
module fcp_mcu_model (
  // Clock
  input wire mclk,
  // Register port
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released data inverts so a stale byte is never mistaken for a new one
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= (a == 8'h04) ? (d & 8'hC3) : d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~reg_wdata;
      @(posedge mclk);
    end
  endtask
  task sel(input [7:0] a);
    begin
      @(posedge mclk);
      reg_addr <= a;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule

// ===== verification/tb_top.sv
/* Self-checking bench for fcp_switch_cfg.
   Assumes the microcontroller model and shortened protection timers. */
`timescale 1ns/100ps
module tb_top;
  reg mclk = 1'b0, rst = 1'b1, pv = 1'b0, ce = 1'b1;
  reg short_cmp = 1'b0, oc_cmp = 1'b0, wake_pin = 1'b0, chg_oc = 1'b0, fclr = 1'b0;
  reg div = 1'b0, slong = 1'b0, cdis = 1'b0;
  reg [31:0] lfsr = 32'h667FAD1D;
  reg [15:0] exp_q [$];
  reg [7:0] d, cfg;
  integer err_count = 0, num_checks = 0, i, t;
  wire [7:0] reg_addr, reg_wdata, rd;
  wire reg_wr, chg, dis, ldm, regu, slp, oc_flag, sc_flag, tmp;
  wire [15:0] obs = {rd, chg, dis, ldm, regu, slp, oc_flag, sc_flag, tmp};
  always #4 mclk = ~mclk;
  fcp_mcu_model fcp_mcu_model_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  fcp_switch_cfg #(.OC_TICK_CYC(4), .SC_SHORT_CYC(5), .SC_LONG_CYC(20)) fcp_switch_cfg_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rd), .discharge_time_divider(div),
    .short_long_delay_sel(slong), .charge_oc_auto_off_disable(cdis),
    .charge_oc_event(chg_oc), .discharge_oc_cmp(oc_cmp), .short_cmp(short_cmp),
    .wake_pin(wake_pin), .flag_clear(fclr), .charge_switch_on_q(chg),
    .discharge_switch_on_q(dis), .load_monitor_enable_q(ldm), .regulator_enable_q(regu),
    .sleep_active_q(slp), .balance_clear_q(), .oc_threshold_sel_q(),
    .short_threshold_sel_q(), .discharge_oc_flag_q(oc_flag),
    .short_circuit_flag_q(sc_flag), .temp_sensor_supply_out_q(tmp));
  function [31:0] next_rand(input [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task w(input [7:0] a, input [7:0] v);
    fcp_mcu_model_inst.wr(a, v);
  endtask
  task clr;
    begin
      fclr <= 1'b1;
      cyc(1);
      fclr <= 1'b0;
    end
  endtask
  // Note the expectation, then strobe the monitor once the read data settled
  task look(input [7:0] a, input [15:0] want);
    begin
      fcp_mcu_model_inst.sel(a);
      exp_q.push_back(want);
      pv <= 1'b1;
      @(posedge mclk);
      pv <= 1'b0;
    end
  endtask
  task check(input [15:0] seen, input [15:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("mismatch obs expected %h seen %h", want, seen);
      end
    end
  endtask
  task finish_test;
    begin
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge mclk)
    if (pv) check(obs, exp_q.pop_front());
  initial begin
    #400000;
    err_count = err_count + 1;
    finish_test;
  end
  ////////////////////
  initial begin
    cyc(2);
    rst <= 1'b0;
    look(8'h04, 16'h0010);
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = next_rand(lfsr);
      d = lfsr[7:0] & 8'h43;
      w(8'h04, d);
      w(8'h05, lfsr[15:8]);
      look(8'h04, {d, d[1:0], d[6], 5'h10});
      look(8'h05, {lfsr[15:8], d[1:0], d[6], 5'h10});
    end
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = next_rand(lfsr);
      // Every pairing of divider and short delay is visited once
      slong <= i[0];
      div <= i[0] ^ i[1];
      cdis <= i[1];
      cfg = {i[0], 2'b00, i[1], 2'b00, lfsr[3:2]};
      t = ((i[0] ^ i[1]) ? 4 : 256) << lfsr[3:2];
      w(8'h05, cfg);
      w(8'h04, 8'h02);
      chg_oc <= 1'b1;
      cyc(1);
      chg_oc <= 1'b0;
      look(8'h04, {6'h00, i[1], 1'b0, i[1], 7'h10});
      w(8'h04, 8'h01);
      short_cmp <= 1'b1;
      // Too early for the selected delay, then late enough for it to expire
      cyc(i[0] ? 16 : 1);
      look(8'h04, 16'h0150);
      cyc(i[0] ? 32 : 8);
      short_cmp <= 1'b0;
      look(8'h04, {7'h00, i[1], 1'b0, i[1], 6'h13});
      clr;
      w(8'h04, 8'h01);
      oc_cmp <= 1'b1;
      // A short gap must restart the long delays
      if (t > 200) begin
        cyc(t * 3 / 4);
        oc_cmp <= 1'b0;
        cyc(2);
        oc_cmp <= 1'b1;
      end
      cyc(t - 4);
      look(8'h04, 16'h0150);
      cyc(24);
      oc_cmp <= 1'b0;
      look(8'h04, {7'h00, i[0], 1'b0, i[0], 6'h15});
      clr;
    end
    w(8'h04, 8'hC3);
    look(8'h04, 16'hC028);
    look(8'h05, {cfg, 8'h28});
    wake_pin <= 1'b1;
    cyc(8);
    wake_pin <= 1'b0;
    look(8'h04, 16'h4030);
    look(8'h05, {cfg, 8'h30});
    look(8'h09, 16'h0030);
    // A control write while the enable is low must leave the control register alone
    ce <= 1'b0;
    w(8'h04, 8'h03);
    ce <= 1'b1;
    look(8'h04, 16'h4030);
    finish_test;
  end
endmodule
